// File: rtl/fsc_pkg.sv
/*
 * Shared constants and types for the fan smoothing and core rail
 * configuration block: register offsets, field positions, reset values,
 * smoothing factors, timing counts and the supervision state type.
 * Assumes a single 250 MHz clock and an AXI4-Lite register bus.
 */
package fsc_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int unsigned CLK_PERIOD_PS  = 4000;  // 250 MHz clock.
	localparam int unsigned SPINUP_TIME_NS = 2000;  // Fan spin-up pulse length.
	// Least time, so the cycle count rounds up.
	localparam int unsigned SPINUP_CYCLES  =
		(SPINUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ****************************************************************
	// Register map (byte addresses)
	// ****************************************************************
	localparam int unsigned ADDR_W     = 8;
	localparam logic [7:0]  CFG_OFFS   = 8'h10;  // Smoothing and core rail config.
	localparam logic [7:0]  LOCK_OFFS  = 8'h40;  // Config register lock.
	localparam logic [7:0]  STAT_OFFS  = 8'h44;  // Event status, write one to clear.
	localparam logic [7:0]  MASK_OFFS  = 8'h48;  // Alert mask.
	localparam logic [7:0]  LIMIT_OFFS = 8'h4c;  // Core rail low limit.

	// ****************************************************************
	// Fields and reset values
	// ****************************************************************
	localparam int unsigned SLOW_R1_BIT   = 0;
	localparam int unsigned SLOW_LOC_BIT  = 1;
	localparam int unsigned SLOW_R2_BIT   = 2;
	localparam int unsigned CORE_LOW_BIT  = 6;
	localparam int unsigned EXT_BIT       = 7;
	localparam logic [7:0]  CFG_WMASK     = 8'hc7;  // Bits 5:3 are reserved.
	localparam logic [7:0]  CFG_RESET     = 8'h00;
	localparam int unsigned LOCK_BIT      = 0;
	localparam int unsigned CORE_STAT_BIT = 1;
	localparam logic [7:0]  STAT_RESET    = 8'h00;
	localparam logic [7:0]  MASK_RESET    = 8'h00;
	localparam logic [7:0]  LIMIT_RESET   = 8'h00;

	// ****************************************************************
	// Smoothing factors
	// ****************************************************************
	localparam int unsigned SLOW_SHIFT = 2;     // Times four.
	localparam int unsigned EXTRA_NUM  = 1392;  // Plus 39.2 percent.
	localparam int unsigned EXTRA_DEN  = 1000;
	localparam int unsigned NUM_CH     = 3;

	// ****************************************************************
	// Bus responses and states
	// ****************************************************************
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_DECERR = 2'b11;

	typedef enum logic [1:0] {FSC_RUN, FSC_LOW, FSC_SPIN} fsc_state_t;

endpackage

// File: rtl/fsc_smooth.sv
/*
 * One channel of smoothing-time scaling: applies the slow factor and the
 * extra-slow extension to a base smoothing time and registers the result.
 * Assumes base time and enables come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module fsc_smooth
	import fsc_pkg::*;
#(
	parameter int unsigned BASE_W = 8,
	parameter int unsigned EFF_W  = BASE_W + SLOW_SHIFT + 1
)
(
	// Clock and reset.
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// Controls.
	input  wire logic [BASE_W-1:0] base_time,
	input  wire logic              slow_en,
	input  wire logic              extra_en,
	// Result.
	output logic      [EFF_W-1:0]  eff_time_q
);

	localparam int unsigned SCL_W  = BASE_W + SLOW_SHIFT;
	localparam int unsigned PROD_W = SCL_W + 11;

	logic [SCL_W-1:0]  scaled;   // After the slow factor.
	logic [PROD_W-1:0] prod;     // Scaled times the extension numerator.
	logic [EFF_W-1:0]  eff_d;    // Next registered result.

	// Exact divide by a constant costs area but keeps the figure as stated.
	assign scaled = slow_en ? {base_time, {SLOW_SHIFT{1'b0}}}
	                        : SCL_W'(base_time);
	assign prod   = PROD_W'(scaled) * PROD_W'(EXTRA_NUM);
	assign eff_d  = extra_en ? EFF_W'(prod / PROD_W'(EXTRA_DEN)) : EFF_W'(scaled);

	// Register the result so the smoothing engines see a clean value.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			eff_time_q <= '0;
		else
			eff_time_q <= eff_d;
	end

endmodule // fsc_smooth

`default_nettype wire

// File: rtl/fsc_top.sv
/*
 * Fan smoothing and core rail low configuration register with its AXI4-Lite
 * slave, lock, status, mask and low limit, the core rail supervision state
 * machine and per-channel smoothing scaling.
 * Assumes base smoothing times and the core rail reading come from logic on
 * aclk; standby detect and the processor-hot input are asynchronous pins.
 */
// The AXI4-Lite register port is this design's own decision.
// Function
// (R1) Remote one slow bit quadruples its smoothing
// (R2) Local slow bit quadruples its smoothing
// (R3) Remote two slow bit quadruples its smoothing
// (R4) Extra-slow bit adds 39.2 percent everywhere
// (R5) Low reaction needs mode, standby, rail low
// (R6) Entering low sets status bit one
// (R7) Entering low alerts only when unmasked
// (R8) Processor-hot ignored while rail is low
// (R9) Recovery resumes processor-hot monitoring
// (R10) Recovery runs a fan spin-up cycle
// (R11) Register resets to zero
// (R12) Lock makes the register read-only
// (R13) Core rail low drives sleep state
// (R14) Reserved bits read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none

module fsc_top
	import fsc_pkg::*;
#(
	parameter int unsigned BASE_W      = 8,
	parameter int unsigned EFF_W       = BASE_W + SLOW_SHIFT + 1,
	parameter int unsigned SPIN_CYCLES = SPINUP_CYCLES
)
(
	// Clock and reset.
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// AXI4-Lite write address and data.
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	// AXI4-Lite write response.
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	output logic      [1:0]                s_axi_bresp,
	// AXI4-Lite read.
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	input  wire logic [ADDR_W-1:0]         s_axi_araddr,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic      [31:0]               s_axi_rdata,
	output logic      [1:0]                s_axi_rresp,
	// Monitor inputs.
	input  wire logic                      standby_power,
	input  wire logic [7:0]                core_rail_code,
	input  wire logic                      processor_hot_input,
	// Smoothing times in and scaled out.
	input  wire logic [NUM_CH*BASE_W-1:0]  base_smooth_time,
	output logic      [NUM_CH*EFF_W-1:0]   eff_smooth_time,
	// Outputs to the rest of the monitor.
	output logic                           smbus_alert_n,
	output logic                           processor_hot_active,
	output logic                           sleep_request,
	output logic                           fan_spinup
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic stby_s1_q, stby_s2_q;  // Standby detect, two stages.
	logic hot_s1_q,  hot_s2_q;   // Processor-hot pin, two stages.

	// Pins are asynchronous to aclk; only the second stage is read.
	always_ff @(posedge aclk)
	begin
		stby_s1_q <= standby_power;
		stby_s2_q <= stby_s1_q;
		hot_s1_q  <= processor_hot_input;
		hot_s2_q  <= hot_s1_q;
	end

	// ****************************************************************
	// Bus write path
	// ****************************************************************
	logic              aw_q, w_q;         // Held address and data phases.
	logic [ADDR_W-1:0] awaddr_q;          // Held write address.
	logic [31:0]       wdata_q;           // Held write data.
	logic              wstb0_q;           // Byte lane zero strobe.
	logic              bvalid_q;          // Write response pending.
	logic [1:0]        bresp_q;           // Write response code.
	logic              do_wr;             // Write performed this cycle.
	logic              wr_cfg, wr_lock, wr_stat, wr_mask, wr_limit, wr_hit;

	assign s_axi_awready = !aw_q && !bvalid_q;
	assign s_axi_wready  = !w_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign do_wr         = aw_q && w_q && !bvalid_q;

	// Decode on word address; the low two bits are ignored.
	assign wr_cfg   = awaddr_q[7:2] == CFG_OFFS[7:2];
	assign wr_lock  = awaddr_q[7:2] == LOCK_OFFS[7:2];
	assign wr_stat  = awaddr_q[7:2] == STAT_OFFS[7:2];
	assign wr_mask  = awaddr_q[7:2] == MASK_OFFS[7:2];
	assign wr_limit = awaddr_q[7:2] == LIMIT_OFFS[7:2];
	assign wr_hit   = wr_cfg || wr_lock || wr_stat || wr_mask || wr_limit;

	// Address and data are caught in either order, then answered once.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q     <= 1'b0;
			w_q      <= 1'b0;
			awaddr_q <= '0;
			wdata_q  <= '0;
			wstb0_q  <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstb0_q <= s_axi_wstrb[0];
			end
			if (do_wr)
			begin
				aw_q     <= 1'b0;
				w_q      <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= wr_hit ? RESP_OKAY : RESP_DECERR;
			end
			else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [7:0] cfg_q, cfg_d;      // Smoothing and core rail config.
	logic       lock_q;            // Config register lock, sticky until reset.
	logic [7:0] stat_q, stat_d;    // Event status.
	logic [7:0] mask_q;            // Alert mask.
	logic [7:0] limit_q;           // Core rail low limit.
	logic       cfg_we, enter_low;
	logic [7:0] stat_set, stat_clr;

	// A locked register accepts the bus write but keeps its value.
	assign cfg_we = do_wr && wr_cfg && wstb0_q && !lock_q;  // [R12]
	// Reserved bits are never stored, so they read back as zero.
	assign cfg_d  = cfg_we ? (wdata_q[7:0] & CFG_WMASK) : cfg_q;  // [R14]

	assign stat_set = 8'(enter_low) << CORE_STAT_BIT;  // [R6]
	assign stat_clr = (do_wr && wr_stat && wstb0_q) ? wdata_q[7:0] : 8'h00;
	// A clear landing with a new event loses to the event.
	assign stat_d   = (stat_q & ~stat_clr) | stat_set;

	// Register updates.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_q   <= CFG_RESET;  // [R11]
			lock_q  <= 1'b0;
			stat_q  <= STAT_RESET;
			mask_q  <= MASK_RESET;
			limit_q <= LIMIT_RESET;
		end
		else
		begin
			cfg_q  <= cfg_d;
			stat_q <= stat_d;
			if (do_wr && wr_lock && wstb0_q && wdata_q[LOCK_BIT])
				lock_q <= 1'b1;
			if (do_wr && wr_mask && wstb0_q)
				mask_q <= wdata_q[7:0];
			if (do_wr && wr_limit && wstb0_q)
				limit_q <= wdata_q[7:0];
		end
	end

	// ****************************************************************
	// Bus read path
	// ****************************************************************
	logic        rvalid_q;   // Read data pending.
	logic [31:0] rdata_q;    // Read data.
	logic [1:0]  rresp_q;    // Read response code.
	logic [7:0]  rd_mux;     // Selected register.
	logic        rd_hit;     // Read address is mapped.
	logic [5:0]  rd_word;    // Word address.

	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign rd_word       = s_axi_araddr[7:2];
	assign rd_hit = (rd_word == CFG_OFFS[7:2]) || (rd_word == LOCK_OFFS[7:2]) ||
	                (rd_word == STAT_OFFS[7:2]) || (rd_word == MASK_OFFS[7:2]) ||
	                (rd_word == LIMIT_OFFS[7:2]);
	assign rd_mux =
		(rd_word == CFG_OFFS[7:2])   ? cfg_q :
		(rd_word == LOCK_OFFS[7:2])  ? {7'h00, lock_q} :
		(rd_word == STAT_OFFS[7:2])  ? stat_q :
		(rd_word == MASK_OFFS[7:2])  ? mask_q :
		(rd_word == LIMIT_OFFS[7:2]) ? limit_q : 8'h00;

	// One read at a time; data follow the address by one cycle.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rdata_q  <= {24'h000000, rd_mux};
			rresp_q  <= rd_hit ? RESP_OKAY : RESP_DECERR;
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// ****************************************************************
	// Core rail supervision
	// ****************************************************************
	localparam int unsigned CNT_W = $clog2(SPIN_CYCLES + 1);

	fsc_state_t       state_q, state_d;  // Supervision state.
	logic [CNT_W-1:0] spin_q, spin_d;    // Spin-up cycles left.
	logic             low_now;           // Low condition this cycle.
	logic             alert_n_q;         // Alert pin, active low.
	logic             hot_q, sleep_q, spin_out_q;

	// Only acts on standby power with the mode enabled.
	assign low_now   = cfg_q[CORE_LOW_BIT] && stby_s2_q &&
	                   (core_rail_code < limit_q);  // [R5]
	assign enter_low = low_now && (state_q != FSC_LOW);

	// Next state: low wins over a spin-up in progress.
	always_comb
	begin
		state_d = state_q;
		spin_d  = spin_q;
		case (state_q)
			FSC_RUN:
				if (low_now)
					state_d = FSC_LOW;
			FSC_LOW:
				if (!low_now)
				begin
					state_d = FSC_SPIN;  // [R10]
					spin_d  = CNT_W'(SPIN_CYCLES);
				end
			FSC_SPIN:
				if (low_now)
					state_d = FSC_LOW;
				else if (spin_q <= CNT_W'(1))
					state_d = FSC_RUN;
				else
					spin_d = spin_q - CNT_W'(1);
			default:
				state_d = FSC_RUN;
		endcase
	end

	// State and registered outputs.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q    <= FSC_RUN;
			spin_q     <= '0;
			alert_n_q  <= 1'b1;
			hot_q      <= 1'b0;
			sleep_q    <= 1'b0;
			spin_out_q <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			spin_q     <= spin_d;
			alert_n_q  <= !(stat_d[CORE_STAT_BIT] && !mask_q[CORE_STAT_BIT]);  // [R7]
			hot_q      <= hot_s2_q && (state_d != FSC_LOW);  // [R8] [R9]
			sleep_q    <= state_d == FSC_LOW;  // [R13]
			spin_out_q <= state_d == FSC_SPIN;  // [R10]
		end
	end

	assign smbus_alert_n        = alert_n_q;
	assign processor_hot_active = hot_q;
	assign sleep_request        = sleep_q;
	assign fan_spinup           = spin_out_q;

	// ****************************************************************
	// Smoothing scaling, one per temperature channel
	// ****************************************************************
	// Channel order matches slow bit order: remote one, local, remote two.
	for (genvar ch = 0; ch < NUM_CH; ch++)
	begin : g_ch
		fsc_smooth #(.BASE_W(BASE_W), .EFF_W(EFF_W)) u_smooth
		(
			.aclk       (aclk),
			.aresetn    (aresetn),
			.base_time  (base_smooth_time[ch*BASE_W +: BASE_W]),
			.slow_en    (cfg_q[ch]),  // [R1] [R2] [R3]
			.extra_en   (cfg_q[EXT_BIT]),  // [R4]
			.eff_time_q (eff_smooth_time[ch*EFF_W +: EFF_W])
		);
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_slow_r1;
		cfg_q[SLOW_R1_BIT] && !cfg_q[EXT_BIT] |=>
			eff_smooth_time[EFF_W-1:0] == EFF_W'({$past(base_smooth_time[BASE_W-1:0]), 2'b00});
	endproperty
	a_slow_r1: assert property (p_slow_r1) else $error("remote one not times four"); // [R1]

	property p_extra;
		!cfg_q[SLOW_LOC_BIT] && cfg_q[EXT_BIT] && base_smooth_time[BASE_W +: BASE_W] == 8'd250
			|=> eff_smooth_time[EFF_W +: EFF_W] == EFF_W'(348);
	endproperty
	a_extra: assert property (p_extra) else $error("extra smoothing not 39.2 percent"); // [R4]

	property p_low_needs_mode;
		!cfg_q[CORE_LOW_BIT] && state_q != FSC_LOW |=> state_q != FSC_LOW;
	endproperty
	a_low_needs_mode: assert property (p_low_needs_mode) else $error("low without mode"); // [R5]

	property p_status_set;
		enter_low |=> stat_q[CORE_STAT_BIT];
	endproperty
	a_status_set: assert property (p_status_set) else $error("status not set"); // [R6]

	property p_alert;
		enter_low ##0 !mask_q[CORE_STAT_BIT] |=> !smbus_alert_n ##0 stat_q[CORE_STAT_BIT];
	endproperty
	a_alert: assert property (p_alert) else $error("alert not raised"); // [R7]

	property p_hot_off;
		state_q == FSC_LOW |-> !processor_hot_active;
	endproperty
	a_hot_off: assert property (p_hot_off) else $error("hot seen while low"); // [R8]

	property p_hot_on;
		$past(hot_s2_q) && state_q != FSC_LOW && $past(aresetn) |-> processor_hot_active;
	endproperty
	a_hot_on: assert property (p_hot_on) else $error("hot not resumed"); // [R9]

	property p_spin;
		state_q == FSC_LOW && !low_now |=> fan_spinup && state_q == FSC_SPIN;
	endproperty
	a_spin: assert property (p_spin) else $error("no spin-up on recovery"); // [R10]

	property p_reset_zero;
		$rose(aresetn) |-> cfg_q == CFG_RESET;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("config not zero"); // [R11]

	property p_lock;
		lock_q && do_wr && wr_cfg |=> $stable(cfg_q);
	endproperty
	a_lock: assert property (p_lock) else $error("locked register written"); // [R12]

	property p_sleep;
		state_q == FSC_LOW |-> sleep_request;
	endproperty
	a_sleep: assert property (p_sleep) else $error("no sleep while low"); // [R13]

	property p_reserved;
		s_axi_rvalid && $past(s_axi_araddr[7:2]) == CFG_OFFS[7:2] && $rose(s_axi_rvalid)
			|-> s_axi_rdata[5:3] == 3'b000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // [R14]

endmodule // fsc_top

`default_nettype wire

// File: bench/test_fsc_top.sv
/*
 * Self-checking testbench for the fan smoothing and core rail config block.
 * Assumes fsc_pkg and fsc_top from rtl/, and that the checks sit in the design.
 */
`timescale 1ns/1ps
`default_nettype none

module test_fsc_top
	import fsc_pkg::*;
;
	// ****************************************************************
	// Signals and settings
	// ****************************************************************
	localparam int SPIN = 4;              // Short spin-up keeps the run brief.
	logic        aclk      = 1'b0;        // 250 MHz clock.
	logic        aresetn   = 1'b0;        // Held low for four cycles.
	logic        awvalid   = 1'b0;        // Write address valid.
	logic [7:0]  awaddr    = 8'h00;       // Write address.
	logic        wvalid    = 1'b0;        // Write data valid.
	logic [31:0] wdata     = 32'h0;       // Write data.
	logic        bready    = 1'b0;        // Write response ready.
	logic        arvalid   = 1'b0;        // Read address valid.
	logic [7:0]  araddr    = 8'h00;       // Read address.
	logic        rready    = 1'b0;        // Read data ready.
	logic        standby   = 1'b0;        // Standby supply pin.
	logic [7:0]  rail      = 8'hff;       // Core rail reading.
	logic        hot       = 1'b0;        // Processor-hot pin.
	logic [23:0] base      = 24'h0;       // Base smoothing times.
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [32:0] eff;                     // Scaled smoothing times.
	logic        alert_n, hot_act, sleep, spinup;
	int          error_cnt = 0;           // Mismatches seen.
	int          n_checks  = 0;           // Comparisons made.

	always #2 aclk = ~aclk;

	fsc_top #(.BASE_W(8), .SPIN_CYCLES(SPIN)) u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .standby_power(standby),
		.core_rail_code(rail), .processor_hot_input(hot),
		.base_smooth_time(base), .eff_smooth_time(eff), .smbus_alert_n(alert_n),
		.processor_hot_active(hot_act), .sleep_request(sleep), .fan_spinup(spinup));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Single comparison point, so every result is counted the same way.
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// Pseudo-random source; a fixed seed keeps runs repeatable.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Expected scaled time: times four when slow, then plus 39.2 percent, rounded down.
	function automatic logic [10:0] exp_eff(input logic [7:0] b, input logic slow,
	                                        input logic ext);
		int x;
		x = int'(b);
		if (slow) x = x * 4;
		if (ext) x = x * 1392 / 1000;
		return x[10:0];
	endfunction

	// Write one word; the opening edge keeps bready from being set twice in a step.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		check("bresp", {30'h0, er}, {30'h0, bresp});
	endtask

	// Read one word and check its response code.
	task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		rready <= 1'b0;
		check("rresp", {30'h0, er}, {30'h0, rresp});
	endtask

	// Read a register and compare its value.
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		axi_rd(a, RESP_OKAY, d);
		check(what, exp, d);
	endtask

	// Compare all three scaled channels against the configuration.
	task automatic chk_eff(input logic [7:0] cfg);
		logic [31:0] e;
		for (int c = 0; c < 3; c++)
		begin
			e = {21'h0, exp_eff(base[c*8+:8], cfg[c], cfg[7])};
			check("eff_time", e, {21'h0, eff[c*11+:11]});
		end
	endtask

	// Ends the run from the main sequence or the watchdog.
	task automatic finish_test();
		if (error_cnt == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		logic [31:0] seed;
		logic [31:0] d;
		logic [7:0]  cfg;
		int          spins;
		seed = 32'h6625;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk("config", CFG_OFFS, 32'h0);
		axi_rd(8'h04, RESP_DECERR, d);
		axi_wr(8'h08, 32'hff, RESP_DECERR);
		// Standby is off here, so the mode bit can be random without side effects.
		for (int i = 0; i < 12; i++)
		begin
			seed = lfsr(seed);
			// Corners: all bits at full scale, then the extension alone on 250.
			cfg = (i == 0) ? 8'hff : (i == 1) ? 8'h80 : seed[7:0];
			base <= (i == 0) ? 24'hffffff : (i == 1) ? 24'h00fa00 : seed[31:8];
			axi_wr(CFG_OFFS, {24'h0, cfg}, RESP_OKAY);
			rd_chk("config", CFG_OFFS, {24'h0, cfg & 8'hc7});
			chk_eff(cfg);
		end
		// Rail low with mode set but no standby supply: nothing may react.
		axi_wr(CFG_OFFS, 32'h40, RESP_OKAY);
		axi_wr(LIMIT_OFFS, 32'h80, RESP_OKAY);
		rail <= 8'h20;
		hot <= 1'b1;
		repeat (6) @(posedge aclk);
		check("sleep", 32'h0, {31'h0, sleep});
		check("hot_active", 32'h1, {31'h0, hot_act});
		rd_chk("status", STAT_OFFS, 32'h0);
		// Standby on: the low reaction starts, alert unmasked.
		standby <= 1'b1;
		repeat (6) @(posedge aclk);
		check("sleep", 32'h1, {31'h0, sleep});
		check("hot_active", 32'h0, {31'h0, hot_act});
		check("alert_n", 32'h0, {31'h0, alert_n});
		rd_chk("status", STAT_OFFS, 32'h2);
		// Recovery: count the spin-up cycles, then monitoring must be back.
		rail <= 8'h90;
		spins = 0;
		repeat (12) @(posedge aclk) spins += int'(spinup === 1'b1);
		check("spin_cycles", SPIN, 32'(spins));
		check("hot_active", 32'h1, {31'h0, hot_act});
		check("sleep", 32'h0, {31'h0, sleep});
		axi_wr(STAT_OFFS, 32'h2, RESP_OKAY);
		repeat (2) @(posedge aclk);
		check("alert_n", 32'h1, {31'h0, alert_n});
		// Masked source: the event is flagged but no alert follows.
		axi_wr(MASK_OFFS, 32'h2, RESP_OKAY);
		rail <= 8'h20;
		repeat (6) @(posedge aclk);
		check("alert_n", 32'h1, {31'h0, alert_n});
		rd_chk("status", STAT_OFFS, 32'h2);
		rail <= 8'h90;
		repeat (12) @(posedge aclk);
		// Lock: later writes are accepted but change nothing.
		axi_wr(LOCK_OFFS, 32'h1, RESP_OKAY);
		axi_wr(CFG_OFFS, 32'h87, RESP_OKAY);
		rd_chk("config", CFG_OFFS, 32'h40);
		// A second reset clears the register and the lock.
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk("config", CFG_OFFS, 32'h0);
		// The lock went with the reset, so the register takes writes again.
		axi_wr(CFG_OFFS, 32'h87, RESP_OKAY);
		rd_chk("config", CFG_OFFS, 32'h87);
		finish_test();
	end

	// Watchdog: the sequence needs well under a thousand cycles.
	initial
	begin
		repeat (5000) @(posedge aclk);
		error_cnt++;
		finish_test();
	end

endmodule // test_fsc_top

`default_nettype wire
